//--- dcfd_defs.svh
// Purpose: Constants of the configuration field decoder
// Assumes: Included by bare name
// Notes: Offsets are byte addresses on the register bus
`ifndef DCFD_DEFS_SVH
`define DCFD_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DCFD_OFS_CTRL 8'h00
`define DCFD_OFS_PAYLOAD 8'h04
`define DCFD_OFS_STATUS 8'h08
`define DCFD_OFS_ALARMS 8'h0c
`define DCFD_OFS_SETUP 8'h10
`define DCFD_OFS_BERWIN 8'h14
`define DCFD_OFS_REPORT 8'h18
// ----------------------------------------
// Field positions
// ----------------------------------------
`define DCFD_CTRL_RESTART 0
`define DCFD_CTRL_CLRERR 1
`define DCFD_ST_ERR 8
`define DCFD_ST_APPLIED 9
`define DCFD_ST_CNT 16
// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define DCFD_RST_MASK 8'h00
`define DCFD_RST_BEREXP 8'h06
`define DCFD_RST_BERWIN 32'd1000000
`define DCFD_CID_LEN 24
`define DCFD_BER_MAX 9
`define DCFD_MAX_FRAMING 8'h03
`define DCFD_MAX_BAUD 8'h08
`define DCFD_MAX_APORT 8'h01
`define DCFD_MAX_IFTYPE 8'h02
`define DCFD_MAX_LINE 8'h03
`define DCFD_MAX_RXMODE 8'h03
`define DCFD_MAX_FLAG 8'h01
`define DCFD_RESP_OKAY 2'b00
`define DCFD_RESP_SLVERR 2'b10
`endif

//--- dcfd_pkg.sv
// Purpose: Types of the configuration field decoder
// Assumes: Nothing
// Notes: Field order is the payload order
package dcfd_pkg;
    typedef enum logic [4:0] {
        F_ALM2 = 5'b00000,
        F_ALM3 = 5'b00001,
        F_ALM4 = 5'b00010,
        F_CALM = 5'b00011,
        F_RSV1 = 5'b00100,
        F_BER = 5'b00101,
        F_CID = 5'b00110,
        F_TLB = 5'b00111,
        F_BLB = 5'b01000,
        F_IFLB = 5'b01001,
        F_RSV2 = 5'b01010,
        F_INV = 5'b01011,
        F_FRM = 5'b01100,
        F_BAUD = 5'b01101,
        F_APORT = 5'b01110,
        F_AIF = 5'b01111,
        F_MPIF = 5'b10000,
        F_LIF = 5'b10001,
        F_PAIR = 5'b10010,
        F_RXMODE = 5'b10011
    } dcfd_field_e;
endpackage

//--- dcfd_field_walker.sv
// Purpose: Steps through payload fields in order
// Assumes: One byte strobe per payload byte
// Notes: Multi-byte identifier is skipped byte by byte
`timescale 1ns/1ps
`default_nettype none
`include "dcfd_defs.svh"
module dcfd_field_walker #(
    parameter int CID_LEN = `DCFD_CID_LEN
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic restart,
    input wire logic byte_stb,
    output var dcfd_pkg::dcfd_field_e field,
    output logic [7:0] cid_cnt
);
    initial begin
        if (CID_LEN < 1 || CID_LEN > 255) begin
            $error("CID_LEN out of range");
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            field <= dcfd_pkg::F_ALM2;
            cid_cnt <= 8'h00;
        end else if (ce) begin
            if (restart) begin
                field <= dcfd_pkg::F_ALM2;
                cid_cnt <= 8'h00;
            end else if (byte_stb) begin
                if (field == dcfd_pkg::F_CID && cid_cnt != 8'(CID_LEN - 1)) begin
                    cid_cnt <= cid_cnt + 8'h01;
                end else if (field == dcfd_pkg::F_RXMODE) begin
                    field <= dcfd_pkg::F_ALM2;
                    cid_cnt <= 8'h00;
                end else begin
                    field <= dcfd_pkg::dcfd_field_e'(field + 5'b00001);
                end
            end
        end
    end

    walk_wrap_a: assert property (@(posedge clk) disable iff (rst)
        ce && !restart && byte_stb && field == dcfd_pkg::F_RXMODE |=> field == dcfd_pkg::F_ALM2)
        else $error("walker did not wrap");
endmodule
`default_nettype wire

//--- dcfd_rx_datapath.sv
// Purpose: Receive data polarity and symbol pair order
// Assumes: One symbol pair per valid cycle
// Notes: Bit 1 is the first symbol of a pair
`timescale 1ns/1ps
`default_nettype none
module dcfd_rx_datapath (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic in_valid,
    input wire logic [1:0] in_pair,
    input wire logic invert,
    input wire logic swap,
    output logic out_valid,
    output logic [1:0] out_pair
);
    logic [1:0] ordered;
    assign ordered = swap ? {in_pair[0], in_pair[1]} : in_pair;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_pair <= 2'b00;
        end else if (ce) begin
            out_valid <= in_valid;
            if (in_valid) begin
                out_pair <= ordered ^ {2{invert}};
            end
        end
    end

    inv_path_a: assert property (@(posedge clk) disable iff (rst)
        ce && in_valid && !swap |=> out_pair == ($past(in_pair) ^ {2{$past(invert)}}))
        else $error("polarity wrong");
    swap_path_a: assert property (@(posedge clk) disable iff (rst)
        ce && in_valid && swap && !invert |=> out_pair == {$past(in_pair[0]), $past(in_pair[1])})
        else $error("pair order wrong");
endmodule
`default_nettype wire

//--- dcfd_top.sv
// Purpose: Decodes the demodulator configuration payload tail
// Assumes: AXI4-Lite master, one write and one read at a time
// Notes: Settings apply only after a full, valid payload
//
// Contract
// - Mask bit zero hides its fault, one lets it be reported.
// - Second mask: underflow, overflow, under 10%, over 90%, logic, downconverter.
// - Third mask: eight lock faults from IF synthesizer to frame sync.
// - Fourth mask: four activity faults, upper four bits spare.
// - BER byte n gives a window of ten to the n bits.
// - Terrestrial, baseband and IF loopback enabled by one, off by zero.
// - Invert byte one inverts every received data bit.
// - Framing codes: none, 1/16 IBS, 1/16 async, 96 kbit IDR.
// - Baud codes 0..8 map to 1200 through 600 baud.
// - Async port type: 0 RS-232, 1 RS-485.
// - Async and multiprotocol interface: 0 V.35, 1 RS-422, 2 RS-232.
// - Line interface: T1 AMI, T1 B8ZS, balanced E1, unbalanced E1.
// - Symbol pairing byte applies always; one swaps paired symbols.
// - Receive mode: closed net, IDR, IBS, drop and insert.
`timescale 1ns/1ps
`default_nettype none
`include "dcfd_defs.svh"
module dcfd_top #(
    parameter int CID_LEN = `DCFD_CID_LEN,
    parameter int BER_MAX = `DCFD_BER_MAX
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    output logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    input wire logic [5:0] FAULT_BUF,
    input wire logic [7:0] FAULT_LOCK,
    input wire logic [3:0] FAULT_ACT,
    output logic [5:0] REPORT_BUF,
    output logic [7:0] REPORT_LOCK,
    output logic [3:0] REPORT_ACT,
    output logic LOOP_TERR,
    output logic LOOP_BB,
    output logic LOOP_IF,
    output logic [1:0] FRAMING,
    output logic [3:0] BAUD_CODE,
    output logic PORT_RS485,
    output logic [1:0] ASYNC_IF,
    output logic [1:0] MPROT_IF,
    output logic [1:0] LINE_IF,
    output logic [1:0] RX_MODE,
    output logic [31:0] BER_WINDOW,
    input wire logic RX_VALID,
    input wire logic [1:0] RX_PAIR,
    output logic RXO_VALID,
    output logic [1:0] RXO_PAIR
);
    initial begin
        if (BER_MAX < 0 || BER_MAX > 9) begin
            $error("BER_MAX must fit 32 bits");
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] pow10(input logic [7:0] n);
        logic [31:0] v;
        v = 32'h0000_0001;
        for (int i = 0; i < 9; i++) begin
            if (8'(i) < n) begin
                v = 32'(v * 32'd10);
            end
        end
        return v;
    endfunction

    function automatic logic in_range(input logic [7:0] v, input logic [7:0] lim);
        return v <= lim;
    endfunction

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic wr_go;
    logic rd_go;
    logic wr_hit;
    logic byte_stb;
    logic restart;
    logic clr_err;
    assign wr_go = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_AWREADY && !S_AXI_BVALID;
    assign rd_go = S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
    assign wr_hit = S_AXI_AWADDR == `DCFD_OFS_CTRL || S_AXI_AWADDR == `DCFD_OFS_PAYLOAD;
    assign byte_stb = CE && wr_go && S_AXI_AWADDR == `DCFD_OFS_PAYLOAD && S_AXI_WSTRB[0];
    assign restart = wr_go && S_AXI_AWADDR == `DCFD_OFS_CTRL && S_AXI_WSTRB[0]
        && S_AXI_WDATA[`DCFD_CTRL_RESTART];
    assign clr_err = wr_go && S_AXI_AWADDR == `DCFD_OFS_CTRL && S_AXI_WSTRB[0]
        && S_AXI_WDATA[`DCFD_CTRL_CLRERR];

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `DCFD_RESP_OKAY;
        end else if (CE) begin
            S_AXI_AWREADY <= wr_go;
            S_AXI_WREADY <= wr_go;
            if (wr_go) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_hit ? `DCFD_RESP_OKAY : `DCFD_RESP_SLVERR;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Field latching
    // ----------------------------------------
    dcfd_pkg::dcfd_field_e field;
    logic [7:0] cid_cnt;
    logic [7:0] b;
    logic byte_ok;
    logic frame_bad;
    logic last_byte;
    logic [7:0] sh_alm2, sh_alm3, sh_alm4, sh_ber;
    logic [7:0] sh_loop, sh_frm, sh_baud, sh_port, sh_aif, sh_mpif, sh_lif;
    logic sh_inv;
    logic sh_pair;
    assign b = S_AXI_WDATA[7:0];
    assign last_byte = byte_stb && field == dcfd_pkg::F_RXMODE;

    dcfd_field_walker #(
        .CID_LEN(CID_LEN)
    ) u_walk (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .restart(restart),
        .byte_stb(byte_stb),
        .field(field),
        .cid_cnt(cid_cnt)
    );

    // Out-of-range codes poison the whole payload rather than half-apply it
    always_comb begin
        unique case (field)
            dcfd_pkg::F_RSV1, dcfd_pkg::F_RSV2: byte_ok = b == 8'h00;
            dcfd_pkg::F_BER: byte_ok = in_range(b, 8'(BER_MAX));
            dcfd_pkg::F_TLB, dcfd_pkg::F_BLB, dcfd_pkg::F_IFLB,
            dcfd_pkg::F_INV, dcfd_pkg::F_PAIR: byte_ok = in_range(b, `DCFD_MAX_FLAG);
            dcfd_pkg::F_FRM: byte_ok = in_range(b, `DCFD_MAX_FRAMING);
            dcfd_pkg::F_BAUD: byte_ok = in_range(b, `DCFD_MAX_BAUD);
            dcfd_pkg::F_APORT: byte_ok = in_range(b, `DCFD_MAX_APORT);
            dcfd_pkg::F_AIF, dcfd_pkg::F_MPIF: byte_ok = in_range(b, `DCFD_MAX_IFTYPE);
            dcfd_pkg::F_LIF: byte_ok = in_range(b, `DCFD_MAX_LINE);
            dcfd_pkg::F_RXMODE: byte_ok = in_range(b, `DCFD_MAX_RXMODE);
            default: byte_ok = 1'b1;
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sh_alm2 <= `DCFD_RST_MASK;
            sh_alm3 <= `DCFD_RST_MASK;
            sh_alm4 <= `DCFD_RST_MASK;
            sh_ber <= `DCFD_RST_BEREXP;
            sh_loop <= 8'h00;
            sh_inv <= 1'b0;
            sh_frm <= 8'h00;
            sh_baud <= 8'h00;
            sh_port <= 8'h00;
            sh_aif <= 8'h00;
            sh_mpif <= 8'h00;
            sh_lif <= 8'h00;
            sh_pair <= 1'b0;
        end else if (byte_stb) begin
            unique case (field)
                dcfd_pkg::F_ALM2: sh_alm2 <= b;
                dcfd_pkg::F_ALM3: sh_alm3 <= b;
                dcfd_pkg::F_ALM4: sh_alm4 <= b;
                dcfd_pkg::F_BER: sh_ber <= b;
                dcfd_pkg::F_TLB: sh_loop[0] <= b[0];
                dcfd_pkg::F_BLB: sh_loop[1] <= b[0];
                dcfd_pkg::F_IFLB: sh_loop[2] <= b[0];
                dcfd_pkg::F_INV: sh_inv <= b[0];
                dcfd_pkg::F_FRM: sh_frm <= b;
                dcfd_pkg::F_BAUD: sh_baud <= b;
                dcfd_pkg::F_APORT: sh_port <= b;
                dcfd_pkg::F_AIF: sh_aif <= b;
                dcfd_pkg::F_MPIF: sh_mpif <= b;
                dcfd_pkg::F_LIF: sh_lif <= b;
                dcfd_pkg::F_PAIR: sh_pair <= b[0];
                default: sh_pair <= sh_pair;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            frame_bad <= 1'b0;
        end else if (CE) begin
            if (restart || last_byte) begin
                frame_bad <= 1'b0;
            end else if (byte_stb && !byte_ok) begin
                frame_bad <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Applied configuration
    // ----------------------------------------
    logic apply;
    logic err;
    logic applied;
    logic [7:0] apply_cnt;
    logic [7:0] alm2, alm3, alm4;
    logic inv;
    logic pair;
    assign apply = last_byte && !frame_bad && byte_ok;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            alm2 <= `DCFD_RST_MASK;
            alm3 <= `DCFD_RST_MASK;
            alm4 <= `DCFD_RST_MASK;
            LOOP_TERR <= 1'b0;
            LOOP_BB <= 1'b0;
            LOOP_IF <= 1'b0;
            inv <= 1'b0;
            pair <= 1'b0;
            FRAMING <= 2'b00;
            BAUD_CODE <= 4'h0;
            PORT_RS485 <= 1'b0;
            ASYNC_IF <= 2'b00;
            MPROT_IF <= 2'b00;
            LINE_IF <= 2'b00;
            RX_MODE <= 2'b00;
            BER_WINDOW <= `DCFD_RST_BERWIN;
        end else if (CE && apply) begin
            alm2 <= sh_alm2 & 8'h3f;
            alm3 <= sh_alm3;
            alm4 <= sh_alm4 & 8'h0f;
            {LOOP_IF, LOOP_BB, LOOP_TERR} <= sh_loop[2:0];
            inv <= sh_inv;
            pair <= sh_pair;
            FRAMING <= sh_frm[1:0];
            BAUD_CODE <= sh_baud[3:0];
            PORT_RS485 <= sh_port[0];
            ASYNC_IF <= sh_aif[1:0];
            MPROT_IF <= sh_mpif[1:0];
            LINE_IF <= sh_lif[1:0];
            RX_MODE <= b[1:0];
            BER_WINDOW <= pow10(sh_ber);
        end
    end

    // New error wins over a clear in the same cycle
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            err <= 1'b0;
            applied <= 1'b0;
            apply_cnt <= 8'h00;
        end else if (CE) begin
            if (last_byte && !apply) begin
                err <= 1'b1;
            end else if (clr_err) begin
                err <= 1'b0;
            end
            if (apply) begin
                applied <= 1'b1;
                apply_cnt <= apply_cnt + 8'h01;
            end
        end
    end

    // Spare bits are held at zero so a stray one cannot unmask
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            REPORT_BUF <= 6'h00;
            REPORT_LOCK <= 8'h00;
            REPORT_ACT <= 4'h0;
        end else if (CE) begin
            REPORT_BUF <= FAULT_BUF & alm2[5:0];
            REPORT_LOCK <= FAULT_LOCK & alm3;
            REPORT_ACT <= FAULT_ACT & alm4[3:0];
        end
    end

    dcfd_rx_datapath u_dp (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .in_valid(RX_VALID),
        .in_pair(RX_PAIR),
        .invert(inv),
        .swap(pair),
        .out_valid(RXO_VALID),
        .out_pair(RXO_PAIR)
    );

    // ----------------------------------------
    // Read side
    // ----------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= `DCFD_RESP_OKAY;
        end else if (CE) begin
            S_AXI_ARREADY <= rd_go;
            if (rd_go) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= `DCFD_RESP_OKAY;
                unique case (S_AXI_ARADDR)
                    `DCFD_OFS_STATUS: S_AXI_RDATA <= {8'h00, apply_cnt, 6'h00, applied, err,
                        3'b000, field};
                    `DCFD_OFS_ALARMS: S_AXI_RDATA <= {8'h00, alm4, alm3, alm2};
                    `DCFD_OFS_SETUP: S_AXI_RDATA <= {12'h000, RX_MODE, LINE_IF, MPROT_IF,
                        ASYNC_IF, PORT_RS485, BAUD_CODE, FRAMING, pair, inv, LOOP_IF, LOOP_BB,
                        LOOP_TERR};
                    `DCFD_OFS_BERWIN: S_AXI_RDATA <= BER_WINDOW;
                    `DCFD_OFS_REPORT: S_AXI_RDATA <= {14'h0000, REPORT_ACT, REPORT_LOCK,
                        REPORT_BUF};
                    `DCFD_OFS_CTRL, `DCFD_OFS_PAYLOAD: S_AXI_RDATA <= 32'h0000_0000;
                    default: begin
                        S_AXI_RDATA <= 32'h0000_0000;
                        S_AXI_RRESP <= `DCFD_RESP_SLVERR;
                    end
                endcase
            end else if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    aw_w_pair_a: assert property (@(posedge CLK) disable iff (RST)
        S_AXI_AWREADY == S_AXI_WREADY)
        else $error("address and data taken apart");
    write_resp_a: assert property (@(posedge CLK) disable iff (RST)
        CE && wr_go |=> S_AXI_BVALID && S_AXI_AWREADY)
        else $error("write not answered");
    read_resp_a: assert property (@(posedge CLK) disable iff (RST)
        CE && rd_go |=> S_AXI_RVALID && S_AXI_ARREADY)
        else $error("read not answered");
    apply_last_a: assert property (@(posedge CLK) disable iff (RST)
        CE && $changed(alm3) |-> $past(field) == dcfd_pkg::F_RXMODE)
        else $error("applied before last byte");
    mask_gate_a: assert property (@(posedge CLK) disable iff (RST)
        $past(CE) |-> REPORT_LOCK == ($past(FAULT_LOCK) & $past(alm3)))
        else $error("mask gating wrong");
    spare_zero_a: assert property (@(posedge CLK) disable iff (RST)
        alm2[7:6] == 2'b00 && alm4[7:4] == 4'h0)
        else $error("spare mask bit set");
    ber_window_a: assert property (@(posedge CLK) disable iff (RST)
        CE && apply && sh_ber == 8'h06 |=> BER_WINDOW == 32'd1000000)
        else $error("BER window wrong");
    bad_code_a: assert property (@(posedge CLK) disable iff (RST)
        CE && last_byte && frame_bad |=> err && $stable(FRAMING))
        else $error("bad payload applied");
    loop_apply_a: assert property (@(posedge CLK) disable iff (RST)
        CE && apply |=> LOOP_IF == $past(sh_loop[2]) && RX_MODE == $past(b[1:0]))
        else $error("loopback or mode not applied");
endmodule
`default_nettype wire

//--- dcfd_host.sv
// Purpose: Control host model issuing single AXI4-Lite cycles
// Assumes: One write or one read under way at a time
// Notes: Released address and data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module dcfd_host (
    input wire logic clk,
    output logic awvalid,
    input wire logic awready,
    output logic [7:0] awaddr,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    input wire logic bvalid,
    output logic bready,
    input wire logic [1:0] bresp,
    output logic arvalid,
    input wire logic arready,
    output logic [7:0] araddr,
    input wire logic rvalid,
    output logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= d;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wready) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end while (!bvalid);
        bready <= 1'b0;
        r = bresp;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
        end while (!rvalid);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask
endmodule
`default_nettype wire

//--- tb.sv
// Purpose: Self-checking bench of the configuration field decoder
// Assumes: Identifier shortened to one byte
// Notes: Faults held high so reports mirror the masks
`timescale 1ns/1ps
`default_nettype none
`include "dcfd_defs.svh"
module tb;
    logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr, f_lock, r_lock;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb, f_act, r_act, baud;
    logic [1:0] bresp, rresp, resp, frm, aif, mif, lif, mode, rxp, rxo;
    logic [5:0] f_buf, r_buf;
    logic lt, lb, li, p485, rxv, rxov, ce;
    logic [31:0] ber;
    logic [7:0] cfg [20];
    int failures, check_count, cyc;

    dcfd_top #(.CID_LEN(1)) uut (.CLK(clk), .RST(rst), .CE(ce),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .FAULT_BUF(f_buf), .FAULT_LOCK(f_lock), .FAULT_ACT(f_act),
        .REPORT_BUF(r_buf), .REPORT_LOCK(r_lock), .REPORT_ACT(r_act),
        .LOOP_TERR(lt), .LOOP_BB(lb), .LOOP_IF(li), .FRAMING(frm), .BAUD_CODE(baud),
        .PORT_RS485(p485), .ASYNC_IF(aif), .MPROT_IF(mif), .LINE_IF(lif), .RX_MODE(mode),
        .BER_WINDOW(ber), .RX_VALID(rxv), .RX_PAIR(rxp), .RXO_VALID(rxov), .RXO_PAIR(rxo));

    dcfd_host host (.clk(clk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] p10(input int n);
        p10 = 32'd1;
        repeat (n) p10 = p10 * 10;
    endfunction

    // Restart first so a stale partial payload never shifts the fields
    task automatic send(input int n);
        host.wr(`DCFD_OFS_CTRL, 32'h1, resp);
        for (int i = 0; i < n; i++) host.wr(`DCFD_OFS_PAYLOAD, {24'h0, cfg[i]}, resp);
    endtask

    task automatic results();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------
    // Clock, reset and hang guard
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            failures++;
            results();
        end
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        {f_buf, f_lock, f_act} = '1;
        {rxv, rxp} = 3'h0;
        ce = 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(ber, 32'd1000000);
        chk({r_act, r_lock, r_buf, lt, lb, li}, 0);
        $display("test reset done");
        for (int k = 0; k <= 8; k++) begin
            for (int i = 0; i < 20; i++) cfg[i] = 8'h00;
            cfg[0] = 8'(8'hc0 | k * 7);
            cfg[1] = 8'(8'h5a ^ k * 17);
            cfg[2] = 8'(8'hf0 | (15 - k));
            cfg[5] = 8'(k);
            {cfg[7][0], cfg[8][0], cfg[9][0], cfg[11][0], cfg[14][0], cfg[18][0]} = {k[2:0], k[0], k[1], k[2]};
            cfg[12] = 8'(k % 4);
            cfg[13] = 8'(k);
            cfg[15] = 8'(k % 3);
            cfg[16] = 8'((k + 1) % 3);
            cfg[17] = 8'((k + 2) % 4);
            cfg[19] = 8'((k + 1) % 4);
            send(19);
            chk(ber, p10(k == 0 ? 6 : k - 1));
            host.wr(`DCFD_OFS_PAYLOAD, {24'h0, cfg[19]}, resp);
            chk(ber, p10(k));
            chk({lt, lb, li}, k[2:0]);
            chk(frm, k % 4);
            chk(baud, k);
            chk(p485, k[1]);
            chk({aif, mif}, {2'(k % 3), 2'((k + 1) % 3)});
            chk(lif, (k + 2) % 4);
            chk(mode, (k + 1) % 4);
            host.rd(`DCFD_OFS_ALARMS, rd, resp);
            chk(rd, {8'h0, cfg[2] & 8'h0f, cfg[1], cfg[0] & 8'h3f});
            chk({r_act, r_lock, r_buf}, {cfg[2][3:0], cfg[1], cfg[0][5:0]});
            @(posedge clk);
            rxv <= 1'b1;
            rxp <= 2'(k);
            @(posedge clk);
            rxv <= 1'b0;
            @(negedge clk);
            chk({rxov, rxo}, {1'b1, (k[2] ? {rxp[0], rxp[1]} : rxp) ^ {2{k[0]}}});
            $display("test config %0d done", k);
        end
        cfg[12] = 8'h04;
        send(20);
        host.rd(`DCFD_OFS_STATUS, rd, resp);
        chk(rd[`DCFD_ST_ERR], 1'b1);
        chk(rd[23:0], 24'h090300);
        chk({frm, ber}, {2'h0, p10(8)});
        host.rd(`DCFD_OFS_SETUP, rd, resp);
        chk(rd, 32'h0006_2400);
        host.wr(`DCFD_OFS_CTRL, 32'h2, resp);
        chk(resp, `DCFD_RESP_OKAY);
        host.rd(`DCFD_OFS_STATUS, rd, resp);
        chk(rd[`DCFD_ST_ERR], 1'b0);
        host.rd(8'h1c, rd, resp);
        chk({resp, rd}, {`DCFD_RESP_SLVERR, 32'h0});
        host.wr(8'h1c, 32'h0, resp);
        chk(resp, `DCFD_RESP_SLVERR);
        $display("test refusal done");
        ce <= 1'b0;
        f_lock <= 8'h00;
        repeat (3) @(posedge clk);
        chk(r_lock, cfg[1]);
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        chk(r_lock, 8'h00);
        $display("test enable done");
        results();
    end
endmodule
`default_nettype wire
